// *** hw/bsm_consts.svh ***
// register offsets, field positions and sizes of the bcd stack math block
`ifndef BSM_CONSTS_SVH
`define BSM_CONSTS_SVH
`define BSM_ADDR_W 8
`define BSM_CTRL_OFS 8'h00
`define BSM_IMAGE_OFS 8'h04
`define BSM_ACC_OFS 8'h08
`define BSM_STK1_OFS 8'h0C
`define BSM_FLAGS_OFS 8'h10
`define BSM_ISTAT_OFS 8'h14
`define BSM_IMASK_OFS 8'h18
`define BSM_DEPTH 8
`define BSM_OP_LSB 0
`define BSM_LEN_LSB 8
`define BSM_LEN_W 6
`define BSM_START_LSB 16
`define BSM_START_W 5
`define BSM_BUSY_BIT 31
`define BSM_LONG_LEN 6'h20
`define BSM_SHORT_LEN 6'h10
`define BSM_INT_W 3
`define BSM_INT_DONE 0
`define BSM_INT_NONBCD 1
`define BSM_INT_BADCMD 2
`define BSM_BIN_W 27
`define BSM_SHORT_BIN_W 14
`define BSM_TEN 14'h000A
`endif

// *** hw/bsm_pkg.sv ***
// types shared by the bcd stack math block
package bsm_pkg;
`include "bsm_consts.svh"

   typedef enum logic [2:0] {
      FORMATTED_SUBTRACT_OP,
      FORMATTED_MULTIPLY_OP,
      FORMATTED_DIVIDE_OP,
      STACK_ADD_OP,
      STACK_SUBTRACT_OP,
      STACK_PUSH_OP,
      NO_OP
   } bsm_op_e;

   typedef enum logic {IDLE, EXEC} bsm_state_e;

   typedef struct packed {
      logic invalidBcd;
      logic negativeResult;
      logic longCarry;
      logic shortCarry;
      logic longBorrow;
      logic shortBorrow;
      logic zeroResult;
   } bsm_flags_s;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [`BSM_ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } bsm_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } bsm_apb_rsp_s;

   typedef struct packed {
      bsm_state_e fsm;
      bsm_op_e op;
      logic [`BSM_LEN_W-1:0] runLen;
      logic [`BSM_START_W-1:0] runStart;
      logic [31:0] image;
      logic [31:0] acc;
      logic [`BSM_DEPTH-1:0][31:0] stack;
      bsm_flags_s flags;
      logic [`BSM_INT_W-1:0] intStat;
      logic [`BSM_INT_W-1:0] intMask;
      bsm_apb_rsp_s rsp;
      logic irq;
   } bsm_state_s;
endpackage

// *** hw/bsm_bcd_math.sv ***
// bcd formatted and stack math datapath with apb register access
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "bsm_consts.svh"
module bsm_bcd_math
   import bsm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire bsm_apb_req_s apbReq,
   output bsm_apb_rsp_s apbRsp,
   output logic irq
);

   // ****************************************
   // bcd helper functions
   // ****************************************

   // bcd add or subtract, returns {carry, carry at digit four, sum}
   function automatic logic [33:0] bcdAddSub(
      input logic [31:0] a,
      input logic [31:0] b,
      input logic sub
   );
      logic c;
      logic c16;
      logic [4:0] s;
      logic [3:0] bd;
      logic [31:0] r;
      c = sub;
      c16 = 1'b0;
      r = 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
         bd = sub ? 4'h9 - b[i*4 +: 4] : b[i*4 +: 4];
         s = {1'b0, a[i*4 +: 4]} + {1'b0, bd} + {4'h0, c};
         c = (s > 5'h09);
         if (c) begin
            s = s + 5'h06;
         end
         r[i*4 +: 4] = s[3:0];
         if (i == 3) begin
            c16 = c;
         end
      end
      return {c, c16, r};
   endfunction

   // every digit within zero to nine
   function automatic logic isBcd(input logic [31:0] x);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (x[i*4 +: 4] > 4'h9) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // four bcd digits to binary
   function automatic logic [`BSM_SHORT_BIN_W-1:0] toBin(input logic [15:0] x);
      logic [`BSM_SHORT_BIN_W-1:0] r;
      r = '0;
      for (int i = 3; i >= 0; i--) begin
         r = 14'(r * `BSM_TEN + {10'h000, x[i*4 +: 4]});
      end
      return r;
   endfunction

   // binary to eight bcd digits by shift and add three
   function automatic logic [31:0] toBcd(input logic [`BSM_BIN_W-1:0] b);
      logic [31:0] r;
      r = 32'h0000_0000;
      for (int i = `BSM_BIN_W - 1; i >= 0; i--) begin
         for (int k = 0; k < 8; k++) begin
            if (r[k*4 +: 4] > 4'h4) begin
               r[k*4 +: 4] = r[k*4 +: 4] + 4'h3;
            end
         end
         r = {r[30:0], b[i]};
      end
      return r;
   endfunction

   // pick the discrete run, lowest bit to bit zero, zero-filled above
   function automatic logic [31:0] runOperand(
      input logic [31:0] img,
      input logic [`BSM_START_W-1:0] start,
      input logic [`BSM_LEN_W-1:0] len
   );
      logic [31:0] mask;
      mask = ~(32'hFFFF_FFFF << len);
      return (img >> start) & mask;
   endfunction

   // legal command and run length check
   function automatic logic cmdOk(input logic [2:0] code, input logic [5:0] len);
      logic ok;
      ok = 1'b1;
      if (code == FORMATTED_SUBTRACT_OP) begin
         ok = (len != 6'h00) && (len <= `BSM_LONG_LEN);
      end else if (code == FORMATTED_MULTIPLY_OP || code == FORMATTED_DIVIDE_OP) begin
         ok = (len != 6'h00) && (len <= `BSM_SHORT_LEN);
      end else if (code >= NO_OP) begin
         ok = 1'b0;
      end
      return ok;
   endfunction

   // ****************************************
   // state and datapath
   // ****************************************

   localparam bsm_state_s RESET_STATE = '0;

   bsm_state_s q;
   bsm_state_s d;
   logic [31:0] operand;
   logic [33:0] fsubRes;
   logic [33:0] saddRes;
   logic [33:0] ssubRes;
   logic [`BSM_SHORT_BIN_W-1:0] mulA;
   logic [`BSM_SHORT_BIN_W-1:0] mulB;
   logic [31:0] mulRes;
   logic [31:0] quotRes;
   logic [31:0] remRes;
   logic shortOk;
   logic accessWr;

   // operand and arithmetic results from the current state
   assign operand = runOperand(q.image, q.runStart, q.runLen);
   assign fsubRes = bcdAddSub(q.acc, operand, 1'b1);
   assign saddRes = bcdAddSub(q.acc, q.stack[0], 1'b0);
   assign ssubRes = bcdAddSub(q.acc, q.stack[0], 1'b1);
   assign mulA = toBin(q.acc[15:0]);
   assign mulB = toBin(operand[15:0]);
   assign mulRes = toBcd(27'({13'h0000, mulA} * {13'h0000, mulB}));
   assign quotRes = (mulB == '0) ? 32'h0000_0000 :
      toBcd({13'h0000, mulA / mulB});
   assign remRes = (mulB == '0) ? {16'h0000, q.acc[15:0]} :
      toBcd({13'h0000, mulA % mulB});
   assign shortOk = isBcd({16'h0000, q.acc[15:0]}) && isBcd({16'h0000, operand[15:0]});
   assign accessWr = apbReq.psel && apbReq.penable && q.rsp.pready && apbReq.pwrite;

   // next state: bus slave, execution and interrupts
   always_comb begin
      logic [`BSM_INT_W-1:0] intSet;
      logic [`BSM_INT_W-1:0] intClr;
      intSet = '0;
      intClr = '0;
      d = q;
      // setup phase: decode and register the answer
      d.rsp.pready = apbReq.psel && !apbReq.penable;
      d.rsp.pslverr = 1'b0;
      d.rsp.prdata = 32'h0000_0000;
      if (apbReq.psel && !apbReq.penable) begin
         case (apbReq.paddr)
            `BSM_CTRL_OFS: begin
               d.rsp.prdata[`BSM_OP_LSB +: 3] = q.op;
               d.rsp.prdata[`BSM_LEN_LSB +: `BSM_LEN_W] = q.runLen;
               d.rsp.prdata[`BSM_START_LSB +: `BSM_START_W] = q.runStart;
               d.rsp.prdata[`BSM_BUSY_BIT] = (q.fsm == EXEC);
            end
            `BSM_IMAGE_OFS: d.rsp.prdata = q.image;
            `BSM_ACC_OFS: d.rsp.prdata = q.acc;
            `BSM_STK1_OFS: d.rsp.prdata = q.stack[0];
            `BSM_FLAGS_OFS: d.rsp.prdata = 32'(q.flags);
            `BSM_ISTAT_OFS: d.rsp.prdata = 32'(q.intStat);
            `BSM_IMASK_OFS: d.rsp.prdata = 32'(q.intMask);
            default: d.rsp.pslverr = 1'b1;
         endcase
      end
      // access phase: writes take effect
      if (accessWr) begin
         case (apbReq.paddr)
            `BSM_CTRL_OFS: begin
               if (q.fsm == EXEC || !cmdOk(apbReq.pwdata[`BSM_OP_LSB +: 3],
                     apbReq.pwdata[`BSM_LEN_LSB +: `BSM_LEN_W])) begin
                  intSet[`BSM_INT_BADCMD] = 1'b1;
               end else begin
                  d.op = bsm_op_e'(apbReq.pwdata[`BSM_OP_LSB +: 3]);
                  d.runLen = apbReq.pwdata[`BSM_LEN_LSB +: `BSM_LEN_W];
                  d.runStart = apbReq.pwdata[`BSM_START_LSB +: `BSM_START_W];
                  d.fsm = EXEC;
               end
            end
            `BSM_IMAGE_OFS: d.image = apbReq.pwdata;
            `BSM_ACC_OFS: begin
               if (q.fsm == IDLE) begin
                  d.acc = apbReq.pwdata;
               end
            end
            `BSM_ISTAT_OFS: intClr = apbReq.pwdata[`BSM_INT_W-1:0];
            `BSM_IMASK_OFS: d.intMask = apbReq.pwdata[`BSM_INT_W-1:0];
            default: ;
         endcase
      end
      // execution: each op rewrites only the flags it drives
      if (q.fsm == EXEC) begin
         d.fsm = IDLE;
         intSet[`BSM_INT_DONE] = 1'b1;
         unique case (q.op)
            FORMATTED_SUBTRACT_OP: begin
               d.acc = fsubRes[31:0];
               d.flags.zeroResult = (fsubRes[31:0] == 32'h0000_0000);
               d.flags.shortBorrow = !fsubRes[32];
               d.flags.longBorrow = !fsubRes[33];
               d.flags.negativeResult = !fsubRes[33];
               d.flags.invalidBcd = !(isBcd(q.acc) && isBcd(operand));
            end
            FORMATTED_MULTIPLY_OP: begin
               d.acc = mulRes;
               d.flags.zeroResult = (mulRes == 32'h0000_0000);
               d.flags.negativeResult = 1'b0;
               d.flags.invalidBcd = !shortOk;
            end
            FORMATTED_DIVIDE_OP: begin
               d.acc = quotRes;
               d.stack[0] = remRes;
               d.flags.zeroResult = (quotRes == 32'h0000_0000);
               d.flags.negativeResult = 1'b0;
               d.flags.invalidBcd = !shortOk;
            end
            STACK_ADD_OP, STACK_SUBTRACT_OP: begin
               if (q.op == STACK_ADD_OP) begin
                  d.acc = saddRes[31:0];
                  d.flags.zeroResult = (saddRes[31:0] == 32'h0000_0000);
                  d.flags.shortCarry = saddRes[32];
                  d.flags.longCarry = saddRes[33];
                  d.flags.negativeResult = 1'b0;
               end else begin
                  d.acc = ssubRes[31:0];
                  d.flags.zeroResult = (ssubRes[31:0] == 32'h0000_0000);
                  d.flags.shortBorrow = !ssubRes[32];
                  d.flags.longBorrow = !ssubRes[33];
                  d.flags.negativeResult = !ssubRes[33];
               end
               d.flags.invalidBcd = !(isBcd(q.acc) && isBcd(q.stack[0]));
               d.stack[`BSM_DEPTH-2:0] = q.stack[`BSM_DEPTH-1:1];
               d.stack[`BSM_DEPTH-1] = 32'h0000_0000;
            end
            STACK_PUSH_OP: begin
               d.stack[`BSM_DEPTH-1:1] = q.stack[`BSM_DEPTH-2:0];
               d.stack[0] = q.acc;
               intSet[`BSM_INT_DONE] = 1'b1;
            end
            default: intSet[`BSM_INT_BADCMD] = 1'b1;
         endcase
         // flags not written above keep their value
         intSet[`BSM_INT_NONBCD] = d.flags.invalidBcd && (q.op != STACK_PUSH_OP);
      end
      // sticky status: a set in the clearing cycle wins
      d.intStat = (q.intStat & ~intClr) | intSet;
      d.irq = |(d.intStat & d.intMask);
   end

   // state register with synchronous reset
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign apbRsp = q.rsp;
   assign irq = q.irq;

   // ****************************************
   // assertions
   // ****************************************

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   logic execSub;
   logic execAddS;
   logic execSubS;
   assign execSub = (q.fsm == EXEC) && (q.op == FORMATTED_SUBTRACT_OP);
   assign execAddS = (q.fsm == EXEC) && (q.op == STACK_ADD_OP);
   assign execSubS = (q.fsm == EXEC) && (q.op == STACK_SUBTRACT_OP);

   fsub_result_a: assert property (
      execSub |=> q.acc == $past(fsubRes[31:0]) && q.fsm == IDLE)
      else $error("formatted subtract result wrong");

   bad_length_a: assert property (
      accessWr && apbReq.paddr == `BSM_CTRL_OFS && q.fsm == IDLE &&
      apbReq.pwdata[`BSM_LEN_LSB +: `BSM_LEN_W] == 6'h00 &&
      apbReq.pwdata[`BSM_OP_LSB +: 3] == FORMATTED_SUBTRACT_OP
      |=> q.fsm == IDLE ##0 q.intStat[`BSM_INT_BADCMD])
      else $error("zero run length not refused");

   fmul_result_a: assert property (
      q.fsm == EXEC && q.op == FORMATTED_MULTIPLY_OP |=> q.acc == $past(mulRes))
      else $error("formatted multiply result wrong");

   fdiv_result_a: assert property (
      q.fsm == EXEC && q.op == FORMATTED_DIVIDE_OP
      |=> q.acc == $past(quotRes) && q.stack[0] == $past(remRes))
      else $error("formatted divide result wrong");

   sadd_result_a: assert property (
      execAddS |=> q.acc == $past(saddRes[31:0]))
      else $error("stack add result wrong");

   ssub_result_a: assert property (
      execSubS |=> q.acc == $past(ssubRes[31:0]))
      else $error("stack subtract result wrong");

   stack_pop_a: assert property (
      execAddS || execSubS
      |=> q.stack[0] == $past(q.stack[1]) && q.stack[`BSM_DEPTH-1] == 32'h0000_0000)
      else $error("stack not popped");

   zero_flag_a: assert property (
      q.fsm == EXEC && q.op != STACK_PUSH_OP
      |=> q.flags.zeroResult == (q.acc == 32'h0000_0000))
      else $error("zero flag disagrees with accumulator");

   // valid bcd words order like their values, so a plain compare predicts the borrow
   short_borrow_a: assert property (
      execSub && isBcd(q.acc) && isBcd(operand)
      |=> q.flags.shortBorrow == ($past(q.acc[15:0]) < $past(operand[15:0])))
      else $error("short borrow flag wrong");

   long_borrow_a: assert property (
      execSubS && isBcd(q.acc) && isBcd(q.stack[0])
      |=> q.flags.longBorrow == ($past(q.acc) < $past(q.stack[0])))
      else $error("long borrow flag wrong");

   long_carry_a: assert property (
      execAddS |=> q.flags.longCarry == $past(saddRes[33]))
      else $error("long carry flag wrong");

   short_carry_a: assert property (
      execAddS |=> q.flags.shortCarry == $past(saddRes[32]))
      else $error("short carry flag wrong");

   negative_flag_a: assert property (
      execSub || execSubS |=> q.flags.negativeResult == q.flags.longBorrow)
      else $error("negative flag wrong");

   invalid_bcd_a: assert property (
      execSub && !isBcd(operand) |=> q.flags.invalidBcd ##0 q.intStat[`BSM_INT_NONBCD])
      else $error("non-bcd operand not flagged");

   flag_hold_a: assert property (
      q.fsm == EXEC && q.op == FORMATTED_MULTIPLY_OP
      |=> $stable(q.flags.shortCarry) && $stable(q.flags.longBorrow))
      else $error("flag changed by unrelated op");

   irq_level_a: assert property (
      ##1 irq == |($past(d.intStat) & $past(d.intMask)))
      else $error("interrupt level wrong");

   cover_fsub_c: cover property (execSub ##1 q.flags.longBorrow);
   cover_carry_c: cover property (execAddS ##1 q.flags.longCarry);
   cover_div_c: cover property (q.fsm == EXEC && q.op == FORMATTED_DIVIDE_OP);
   cover_irq_c: cover property (q.intStat[`BSM_INT_NONBCD] && irq);

endmodule

// *** tb/bsm_seq_model.sv ***
// sequencer model: apb master issuing register transfers to the math block
`timescale 1ns/100ps
// ************************************
// apb master transfers
// ************************************
module bsm_seq_model
   import bsm_pkg::*;
(
   input wire logic sys_clk,
   output bsm_apb_req_s apbReq,
   input wire bsm_apb_rsp_s apbRsp
);
   initial apbReq = '0;

   // setup cycle, then access held until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge sys_clk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge sys_clk);
      apbReq.penable <= 1'b1;
      do @(posedge sys_clk); while (apbRsp.pready !== 1'b1);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq <= '0;
   endtask
endmodule

// *** tb/bcd_formatted_and_stack_math_tb_top.sv ***
// self-checking bench for the bcd formatted and stack math block
`timescale 1ns/100ps
`include "bsm_consts.svh"
// ************************************
// bench top
// ************************************
module bcd_formatted_and_stack_math_tb_top;
   import bsm_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   bsm_apb_req_s apbReq;
   bsm_apb_rsp_s apbRsp;
   logic irq;
   logic [31:0] rdv;
   logic err;
   logic [6:0] mFl = '0;
   longint mAcc = 0;
   longint mStk[$];
   int fails = 0;
   int n_compared = 0;
   int seedVal;
   // register list for the reset readback, refused command words
   logic [7:0] regs[7] = '{`BSM_CTRL_OFS, `BSM_IMAGE_OFS, `BSM_ACC_OFS, `BSM_STK1_OFS,
                           `BSM_FLAGS_OFS, `BSM_ISTAT_OFS, `BSM_IMASK_OFS};
   logic [31:0] bad[4] = '{32'h0000_0000, 32'h0000_2100, 32'h0000_1101, 32'h0000_0407};

   bsm_bcd_math dut (.sys_clk(sys_clk), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp),
      .irq(irq));
   bsm_seq_model seq (.sys_clk(sys_clk), .apbReq(apbReq), .apbRsp(apbRsp));

   // 125 MHz clock
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   // eight-digit bcd to integer and back, random bcd
   function automatic longint b2i(longint v);
      longint r = 0;
      for (int i = 7; i >= 0; i--) begin
         r = r * 10 + ((v >> (4 * i)) & 15);
      end
      return r;
   endfunction
   function automatic longint i2b(longint v);
      longint r = 0;
      for (int i = 0; i < 8; i++) begin
         r = r | ((v % 10) << (4 * i));
         v = v / 10;
      end
      return r;
   endfunction
   function automatic longint rbcd();
      longint r = 0;
      for (int i = 0; i < 8; i++) begin
         r = r | (longint'($urandom_range(0, 9)) << (4 * i));
      end
      return r;
   endfunction
   function automatic longint top1();
      return (mStk.size() > 0) ? mStk[0] : 0;
   endfunction

   // compare, count, report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      seq.xfer(1'b1, a, d, rdv, err);
   endtask
   task automatic rd(input logic [7:0] a);
      seq.xfer(1'b0, a, 32'h0000_0000, rdv, err);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // issue one op, step the reference model, compare every result
   task automatic run_op(input int code, input int len, input int st, input longint img);
      longint a, b, r, res;
      logic [6:0] f, msk;
      a = b2i(mAcc);
      b = (code < 3) ? b2i((img >> st) & ((longint'(1) << len) - 1)) : b2i(top1());
      wr(`BSM_IMAGE_OFS, img[31:0]);
      wr(`BSM_CTRL_OFS, {11'h000, st[4:0], 2'h0, len[5:0], 5'h00, code[2:0]});
      f = '0;
      msk = 7'h61;
      case (code)
         0, 4: begin
            r = a - b;
            res = (r + 100000000) % 100000000;
            f[1] = (a % 10000) < (b % 10000);
            f[2] = r < 0;
            f[5] = r < 0;
            msk = 7'h67;
         end
         3: begin
            r = a + b;
            res = r % 100000000;
            f[3] = (a % 10000) + (b % 10000) >= 10000;
            f[4] = r >= 100000000;
            msk = 7'h79;
         end
         1: res = (a % 10000) * b;
         2: begin
            res = (b == 0) ? 0 : (a % 10000) / b;
            r = (b == 0) ? (a % 10000) : (a % 10000) % b;
            if (mStk.size() == 0) mStk.push_back(0);
            mStk[0] = i2b(r);
         end
         default: begin
            res = a;
            msk = 7'h00;
            mStk.push_front(mAcc);
            if (mStk.size() > `BSM_DEPTH) void'(mStk.pop_back());
         end
      endcase
      if ((code == 3 || code == 4) && mStk.size() > 0) void'(mStk.pop_front());
      f[0] = res == 0;
      mFl = (mFl & ~msk) | (f & msk);
      mAcc = i2b(res);
      rd(`BSM_ACC_OFS);
      check(rdv, mAcc[31:0]);
      rd(`BSM_STK1_OFS);
      b = top1();
      check(rdv, b[31:0]);
      rd(`BSM_FLAGS_OFS);
      check(rdv, {25'h000_0000, mFl});
      rd(`BSM_ISTAT_OFS);
      check(rdv, 32'h0000_0001);
      check({31'h0000_0000, irq}, 32'h0000_0001);
      wr(`BSM_ISTAT_OFS, 32'h0000_0007);
      repeat (2) @(posedge sys_clk);
      check({31'h0000_0000, irq}, 32'h0000_0000);
   endtask

   // main sequence
   initial begin
      int code, len, st;
      seedVal = $urandom(32'h5009_f998);
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      foreach (regs[i]) begin
         rd(regs[i]);
         check(rdv, 32'h0000_0000);
      end
      rd(8'h1C);
      check({31'h0000_0000, err}, 32'h0000_0001);
      wr(`BSM_IMASK_OFS, 32'h0000_0001);
      for (int k = 0; k < 36; k++) begin
         code = k % 6;
         if (k % 2 == 0) begin
            mAcc = rbcd();
            wr(`BSM_ACC_OFS, mAcc[31:0]);
         end
         if (k == 10) begin
            mAcc = top1();
            wr(`BSM_ACC_OFS, mAcc[31:0]);
         end
         len = (k == 0) ? 32 : (k == 6) ? 1 : (k == 1) ? 16 :
               $urandom_range(1, (code == 0) ? 32 : 16);
         st = 4 * $urandom_range(0, (32 - len) / 4);
         run_op(code, len, st, rbcd());
      end
      // refused commands with the refusal bit masked off
      wr(`BSM_IMASK_OFS, 32'h0000_0003);
      foreach (bad[i]) begin
         wr(`BSM_CTRL_OFS, bad[i]);
         rd(`BSM_ISTAT_OFS);
         check(rdv, 32'h0000_0004);
         rd(`BSM_ACC_OFS);
         check(rdv, mAcc[31:0]);
         check({31'h0000_0000, irq}, 32'h0000_0000);
         wr(`BSM_ISTAT_OFS, 32'h0000_0007);
      end
      // a non-bcd operand digit
      wr(`BSM_IMASK_OFS, 32'h0000_0002);
      wr(`BSM_IMAGE_OFS, 32'h0000_000A);
      wr(`BSM_CTRL_OFS, 32'h0000_0400);
      rd(`BSM_FLAGS_OFS);
      check(rdv & 32'h0000_0040, 32'h0000_0040);
      rd(`BSM_ISTAT_OFS);
      check(rdv, 32'h0000_0003);
      check({31'h0000_0000, irq}, 32'h0000_0001);
      close_out();
   end

   // watchdog against a hung handshake
   initial begin
      #400000;
      fails++;
      close_out();
   end
endmodule
